// ==== logic/mode_reg_defines.vh ====
// Register map, field positions and output levels of the output mode register bank
`ifndef MODE_REG_DEFINES_VH
`define MODE_REG_DEFINES_VH

// ---------------------------------------------------------------
// Sub-addresses
// ---------------------------------------------------------------
`define OUT_MODE_ADDR    8'h03
`define OUT_SEL_ADDR     8'h04

// ---------------------------------------------------------------
// Fields of output_vbi_teletext_mode
// ---------------------------------------------------------------
`define REV_LSB          0
`define REV_MSB          1
`define VBI_PASS_POS     2
`define DAC_ARR_POS      3
`define EXTRA_CHROMA_POS 4
`define TTX_INSERT_POS   5
`define TTX_REQ_MODE_POS 6
`define DEF_COLOR_POS    7
`define OUT_MODE_RST     8'h00
`define OUT_MODE_WMASK   8'hFC

// ---------------------------------------------------------------
// Fields of the adjacent output-select register
// ---------------------------------------------------------------
`define OUT_SEL_POS      0
`define YPBPR_POS        1
`define OUT_SEL_RST      2'h0

// ---------------------------------------------------------------
// DAC codes for forced levels
// ---------------------------------------------------------------
`define BLACK_LEVEL      10'h0F0
`define NEUTRAL_LEVEL    10'h200
`define TTX_HIGH_LEVEL   10'h2E0

`endif

// ==== logic/dac_output_matrix.v ====
// Video source selection and forcing for the three DAC outputs
`timescale 1ns/10ps
module dac_output_matrix (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // Configuration
  input  wire       vbi_pass_bit,
  input  wire       dac_arrangement_bit,
  input  wire       extra_chroma_bit,
  input  wire       teletext_insert_bit,
  input  wire       default_color_bit,
  input  wire       output_select_bit,
  input  wire       component_ypbpr_bit,
  input  wire       slave_mode0,
  input  wire       blank_input_ctrl,
  input  wire [2:0] dac_power_on,
  // Video samples and line status
  input  wire [9:0] cvbs_in,
  input  wire [9:0] luma_in,
  input  wire [9:0] chroma_in,
  input  wire [9:0] red_in,
  input  wire [9:0] green_in,
  input  wire [9:0] blue_in,
  input  wire [9:0] pb_in,
  input  wire [9:0] pr_in,
  input  wire       vbi_line,
  input  wire       pixel_zero,
  input  wire       teletext_window,
  input  wire       teletext_bit,
  // DAC outputs
  output reg  [9:0] dac_a,
  output reg  [9:0] dac_b,
  output reg  [9:0] dac_c,
  output reg  [2:0] dac_enable
);
`include "mode_reg_defines.vh"

  wire       vbi_insert;
  wire       force_black;
  wire       ttx_on;
  reg  [9:0] y_v;
  reg  [9:0] cv_v;
  reg  [9:0] c_v;
  reg  [9:0] r_v;
  reg  [9:0] g_v;
  reg  [9:0] b_v;
  reg  [9:0] pb_v;
  reg  [9:0] pr_v;

  // ---------------------------------------------------------------
  // Blanking, default colour and teletext forcing
  // ---------------------------------------------------------------
  assign vbi_insert  = vbi_pass_bit & ~slave_mode0 & ~blank_input_ctrl;
  assign force_black = (vbi_line & ~vbi_insert) |
                       (pixel_zero & default_color_bit);
  assign ttx_on      = teletext_insert_bit & teletext_window;

  always @* begin
    y_v  = luma_in;
    cv_v = cvbs_in;
    c_v  = chroma_in;
    r_v  = red_in;
    g_v  = green_in;
    b_v  = blue_in;
    pb_v = pb_in;
    pr_v = pr_in;
    if (force_black) begin
      y_v  = `BLACK_LEVEL;
      cv_v = `BLACK_LEVEL;
      r_v  = `BLACK_LEVEL;
      g_v  = `BLACK_LEVEL;
      b_v  = `BLACK_LEVEL;
      c_v  = `NEUTRAL_LEVEL;
      pb_v = `NEUTRAL_LEVEL;
      pr_v = `NEUTRAL_LEVEL;
    end
    if (ttx_on) begin
      y_v  = teletext_bit ? `TTX_HIGH_LEVEL : `BLACK_LEVEL;
      cv_v = y_v;
    end
  end

  // ---------------------------------------------------------------
  // Output matrix, powered-down DACs hold zero
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_a      <= 10'h000;
      dac_b      <= 10'h000;
      dac_c      <= 10'h000;
      dac_enable <= 3'h0;
    end else begin
      dac_enable <= dac_power_on;
      if (!dac_power_on[0]) begin
        dac_a <= 10'h000;
      end else if (dac_arrangement_bit) begin
        dac_a <= (output_select_bit & ~component_ypbpr_bit) ? g_v : y_v;
      end else begin
        dac_a <= extra_chroma_bit ? c_v : cv_v;
      end
      if (!dac_power_on[1]) begin
        dac_b <= 10'h000;
      end else if (output_select_bit) begin
        dac_b <= component_ypbpr_bit ? pb_v : b_v;
      end else begin
        dac_b <= cv_v;
      end
      if (!dac_power_on[2]) begin
        dac_c <= 10'h000;
      end else if (output_select_bit) begin
        dac_c <= component_ypbpr_bit ? pr_v : r_v;
      end else begin
        dac_c <= c_v;
      end
    end
  end

endmodule

// ==== logic/output_mode_regs.v ====
// Output/VBI/teletext mode register with two-wire serial slave and DAC routing
//
// How it works
// - Mode register is eight bits at serial sub-address 03H.
// - Two lowest bits are read-only and return the revision code.
// - VBI pass bit on passes vertical-blanking data, otherwise those lines blank.
// - VBI insertion is disabled while running in slave timing mode zero.
// - Blank-input control overrides VBI pass; no VBI insertion then.
// - Arrangement bit moves DAC A from composite to luma or green.
// - Extra-chroma bit puts chroma on DAC A wherever it would carry composite.
// - Teletext pin data is inserted only when teletext-insert bit is 1.
// - Teletext request is steady high in mode 0, per-bit request in mode 1.
// - Zero pixels show colour 00000000 with bit 0, black with bit 1.
// - Output-select 0: B composite, C chroma; A composite or luma.
// - Output-select 1, RGB: B blue, C red; A composite or green.
// - Output-select 1, YPbPr: B Pb, C Pr; A composite or luma.
// - Each DAC powers on or off independently in every configuration.
// - Output-select bit picks composite or component mode.
// - YPbPr bit switches component DACs from RGB to YPbPr.
`timescale 1ns/10ps
module output_mode_regs #(
  parameter [6:0] SLAVE_ADDR = 7'h2A,  // Arbitrary bus address
  parameter [1:0] REV_CODE   = 2'h1    // Arbitrary revision value
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // Two-wire serial bus
  input  wire       scl_pin,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe_n,
  // Timing status
  input  wire       slave_mode0,
  input  wire       blank_input_ctrl,
  // Teletext
  input  wire       teletext_data_pin,
  input  wire       teletext_window,
  input  wire       teletext_bit_tick,
  output reg        teletext_request_pin,
  // Video
  input  wire [9:0] cvbs_in,
  input  wire [9:0] luma_in,
  input  wire [9:0] chroma_in,
  input  wire [9:0] red_in,
  input  wire [9:0] green_in,
  input  wire [9:0] blue_in,
  input  wire [9:0] pb_in,
  input  wire [9:0] pr_in,
  input  wire       vbi_line,
  input  wire       pixel_zero,
  input  wire [2:0] dac_power_on,
  // DAC outputs
  output wire [9:0] dac_a,
  output wire [9:0] dac_b,
  output wire [9:0] dac_c,
  output wire [2:0] dac_enable
);
`include "mode_reg_defines.vh"

  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_ADDR  = 9'h002;
  localparam [8:0] ST_ACK_A = 9'h004;
  localparam [8:0] ST_SUB   = 9'h008;
  localparam [8:0] ST_ACK_S = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_ACK_W = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_ACK_R = 9'h100;
  localparam [7:0] MODE_RST = `OUT_MODE_RST;

  reg  [2:0] s1_ff;
  reg  [2:0] s2_ff;
  reg  [2:0] s3_ff;
  reg  [2:0] flt_ff;
  reg  [2:0] prev_ff;
  reg  [8:0] state_ff;
  reg  [3:0] bit_cnt_ff;
  reg  [7:0] shift_ff;
  reg  [7:0] tx_ff;
  reg  [7:0] sub_ff;
  reg        nack_ff;
  reg  [7:2] mode_ff;
  reg  [1:0] sel_ff;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire [7:0] rd_data;

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  // Register values come in as arguments so the read mux follows every write
  function [7:0] read_reg;
    input [7:0] addr;
    input [7:2] mode;
    input [1:0] sel;
    begin
      case (addr)
        `OUT_MODE_ADDR: read_reg = {mode, REV_CODE};
        `OUT_SEL_ADDR:  read_reg = {6'h00, sel};
        default:        read_reg = 8'h00;
      endcase
    end
  endfunction

  assign rd_data = read_reg(sub_ff, mode_ff, sel_ff);
  assign sda_out = 1'b0;

  // ---------------------------------------------------------------
  // Pin synchronisers: bit 0 clock, bit 1 data, bit 2 teletext
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff   <= 3'h3;
      s2_ff   <= 3'h3;
      s3_ff   <= 3'h3;
      flt_ff  <= 3'h3;
      prev_ff <= 3'h3;
    end else begin
      s1_ff   <= {teletext_data_pin, sda_in, scl_pin};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      flt_ff  <= (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
      prev_ff <= flt_ff;
    end
  end

  assign scl_rise  = flt_ff[0] & ~prev_ff[0];
  assign scl_fall  = ~flt_ff[0] & prev_ff[0];
  assign start_det = flt_ff[0] & prev_ff[0] & ~flt_ff[1] & prev_ff[1];
  assign stop_det  = flt_ff[0] & prev_ff[0] & flt_ff[1] & ~prev_ff[1];

  // ---------------------------------------------------------------
  // Serial slave with sub-address auto-increment
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      tx_ff      <= 8'h00;
      sub_ff     <= 8'h00;
      nack_ff    <= 1'b1;
      sda_oe_n   <= 1'b1;
      mode_ff    <= MODE_RST[7:2];
      sel_ff     <= `OUT_SEL_RST;
    end else if (start_det) begin
      state_ff   <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_n   <= 1'b1;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      if (state_ff == ST_ACK_R) begin
        nack_ff <= flt_ff[1];
      end else if (state_ff != ST_IDLE && state_ff != ST_ACK_A &&
                   state_ff != ST_ACK_S && state_ff != ST_ACK_W) begin
        shift_ff   <= {shift_ff[6:0], flt_ff[1]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (shift_ff[7:1] == SLAVE_ADDR) begin
              sda_oe_n <= 1'b0;
              state_ff <= shift_ff[0] ? ST_ACK_R : ST_ACK_A;
              nack_ff  <= 1'b0;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          sda_oe_n <= 1'b1;
          state_ff <= ST_SUB;
        end
        ST_SUB: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            sub_ff     <= shift_ff;
            sda_oe_n   <= 1'b0;
            state_ff   <= ST_ACK_S;
          end
        end
        ST_ACK_S, ST_ACK_W: begin
          sda_oe_n <= 1'b1;
          state_ff <= ST_WDATA;
        end
        ST_WDATA: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (sub_ff == `OUT_MODE_ADDR) begin
              mode_ff <= shift_ff[7:2];
            end
            if (sub_ff == `OUT_SEL_ADDR) begin
              sel_ff <= shift_ff[1:0];
            end
            sub_ff   <= sub_ff + 8'h01;
            sda_oe_n <= 1'b0;
            state_ff <= ST_ACK_W;
          end
        end
        ST_RDATA: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            sub_ff     <= sub_ff + 8'h01;
            sda_oe_n   <= 1'b1;
            state_ff   <= ST_ACK_R;
          end else begin
            tx_ff    <= {tx_ff[6:0], 1'b0};
            sda_oe_n <= tx_ff[6];
          end
        end
        ST_ACK_R: begin
          if (nack_ff) begin
            sda_oe_n <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            tx_ff      <= rd_data;
            sda_oe_n   <= rd_data[7];
            bit_cnt_ff <= 4'h0;
            state_ff   <= ST_RDATA;
          end
        end
        default: begin
          sda_oe_n <= 1'b1;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Teletext request
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      teletext_request_pin <= 1'b0;
    end else begin
      teletext_request_pin <= teletext_window & mode_ff[`TTX_INSERT_POS] &
                              (~mode_ff[`TTX_REQ_MODE_POS] | teletext_bit_tick);
    end
  end

  // ---------------------------------------------------------------
  // DAC routing
  // ---------------------------------------------------------------
  dac_output_matrix u_matrix (
    .core_clk            (core_clk),
    .reset_n             (reset_n),
    .vbi_pass_bit        (mode_ff[`VBI_PASS_POS]),
    .dac_arrangement_bit (mode_ff[`DAC_ARR_POS]),
    .extra_chroma_bit    (mode_ff[`EXTRA_CHROMA_POS]),
    .teletext_insert_bit (mode_ff[`TTX_INSERT_POS]),
    .default_color_bit   (mode_ff[`DEF_COLOR_POS]),
    .output_select_bit   (sel_ff[`OUT_SEL_POS]),
    .component_ypbpr_bit (sel_ff[`YPBPR_POS]),
    .slave_mode0         (slave_mode0),
    .blank_input_ctrl    (blank_input_ctrl),
    .dac_power_on        (dac_power_on),
    .cvbs_in             (cvbs_in),
    .luma_in             (luma_in),
    .chroma_in           (chroma_in),
    .red_in              (red_in),
    .green_in            (green_in),
    .blue_in             (blue_in),
    .pb_in               (pb_in),
    .pr_in               (pr_in),
    .vbi_line            (vbi_line),
    .pixel_zero          (pixel_zero),
    .teletext_window     (teletext_window),
    .teletext_bit        (flt_ff[2]),
    .dac_a               (dac_a),
    .dac_b               (dac_b),
    .dac_c               (dac_c),
    .dac_enable          (dac_enable)
  );

endmodule

// ==== dv/output_mode_regs_properties.sv ====
// Concurrent checks on the output mode register bank pins
`timescale 1ns/10ps
module output_mode_regs_properties (
  // Clock and reset
  input wire       core_clk,
  input wire       reset_n,
  // Observed pins
  input wire       scl_pin,
  input wire       sda_out,
  input wire       sda_oe_n,
  input wire       slave_mode0,
  input wire       blank_input_ctrl,
  input wire       teletext_window,
  input wire       teletext_request_pin,
  input wire       vbi_line,
  input wire [2:0] dac_power_on,
  input wire [9:0] dac_a,
  input wire [9:0] dac_b,
  input wire [9:0] dac_c,
  input wire [2:0] dac_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_dac_a_off: assert property (!dac_power_on[0] |=> dac_a == 10'h000)
    else $error("dac a not silent while off");
  chk_dac_c_off: assert property (!dac_power_on[2] |=> dac_c == 10'h000)
    else $error("dac c not silent while off");
  chk_enable_copy: assert property (1'b1 |=> dac_enable == $past(dac_power_on))
    else $error("dac enable does not follow power request");
  chk_slave_vbi_blank: assert property (vbi_line && slave_mode0 && !teletext_window
    && dac_power_on[1] |=> dac_b inside {10'h0F0, 10'h200})
    else $error("blanking data passed in slave mode zero");
  chk_blank_ctrl_wins: assert property (vbi_line && blank_input_ctrl && dac_power_on[2]
    |=> dac_c inside {10'h0F0, 10'h200})
    else $error("blanking data passed under blank input control");
  chk_request_window: assert property (!teletext_window |=> !teletext_request_pin)
    else $error("teletext request outside window");
  chk_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_pin && !$past(scl_pin, 3))
    else $error("data line pulled while clock high");
  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data output not open drain");

  cover property (teletext_request_pin);
  cover property ($fell(sda_oe_n));
  cover property (vbi_line && slave_mode0);
endmodule

// ==== dv/serial_host_model.sv ====
// Two-wire bus master standing in for the host processor
`timescale 1ns/10ps
module serial_host_model #(
  parameter [6:0] DEV_ADDR = 7'h2A
) (
  // Bus pins
  input  wire core_clk,
  input  wire sda_line,
  output reg  scl_pin,
  output reg  sda_drv
);
  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
  end
  task half;
    begin
      repeat (8) @(posedge core_clk);
      #1;
    end
  endtask
  // Clock low, then a short hold before data may change
  task low;
    begin
      scl_pin = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
  task start;
    begin
      sda_drv = 1'b1;
      half;
      scl_pin = 1'b1;
      half;
      sda_drv = 1'b0;
      half;
      low;
    end
  endtask
  task stop;
    begin
      sda_drv = 1'b0;
      half;
      scl_pin = 1'b1;
      half;
      sda_drv = 1'b1;
      half;
    end
  endtask
  task xfer(input [7:0] tx, input mack, output [7:0] rx, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_drv = tx[i];
        half;
        scl_pin = 1'b1;
        half;
        rx[i] = sda_line;
        low;
      end
      sda_drv = ~mack;
      half;
      scl_pin = 1'b1;
      half;
      ack = ~sda_line;
      low;
    end
  endtask
  task wr(input [7:0] sub, input [15:0] d, input two, output ok);
    reg [7:0] r;
    reg       a0, a1, a2, a3;
    begin
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b0, r, a0);
      xfer(sub, 1'b0, r, a1);
      xfer(d[7:0], 1'b0, r, a2);
      a3 = 1'b1;
      if (two)
        xfer(d[15:8], 1'b0, r, a3);
      stop;
      ok = a0 & a1 & a2 & a3;
    end
  endtask
  task rd(input [7:0] sub, output [7:0] q, output ok);
    reg [7:0] r;
    reg       a0, a1, a2, a3;
    begin
      start;
      xfer({DEV_ADDR, 1'b0}, 1'b0, r, a0);
      xfer(sub, 1'b0, r, a1);
      start;
      xfer({DEV_ADDR, 1'b1}, 1'b0, r, a2);
      xfer(8'hFF, 1'b0, q, a3);
      stop;
      ok = a0 & a1 & a2;
    end
  endtask
endmodule

// ==== dv/output_mode_regs_tb.sv ====
// Self-checking bench for the output mode register bank
`timescale 1ns/10ps
module output_mode_regs_tb;
  localparam [7:0] REV = 8'h01;
  reg        core_clk = 1'b0;
  reg        reset_n = 1'b0;
  reg        slave_mode0 = 1'b0;
  reg        blank_ctrl = 1'b0;
  reg        ttx_pin = 1'b0;
  reg        ttx_win = 1'b0;
  reg        ttx_tick = 1'b0;
  reg        vbi_line = 1'b0;
  reg        pixel_zero = 1'b0;
  reg  [2:0] power = 3'h7;
  reg  [9:0] base = 10'h100;
  wire       scl, sda_drv, sda_out, sda_oe_n, ttx_req;
  wire [9:0] dac_a, dac_b, dac_c;
  wire [2:0] dac_enable;
  wire       sda_line = sda_oe_n & sda_drv;
  integer    fail_count = 0;
  integer    comparisons = 0;
  integer    i;
  reg        ok;
  reg  [7:0] q;

  always #50 core_clk = ~core_clk;

  output_mode_regs #(.REV_CODE(REV[1:0])) uut (
    .core_clk(core_clk), .reset_n(reset_n), .scl_pin(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_mode0(slave_mode0),
    .blank_input_ctrl(blank_ctrl), .teletext_data_pin(ttx_pin),
    .teletext_window(ttx_win), .teletext_bit_tick(ttx_tick),
    .teletext_request_pin(ttx_req), .cvbs_in(base + 10'h001), .luma_in(base + 10'h002),
    .chroma_in(base + 10'h003), .red_in(base + 10'h004), .green_in(base + 10'h005),
    .blue_in(base + 10'h006), .pb_in(base + 10'h007), .pr_in(base + 10'h008),
    .vbi_line(vbi_line), .pixel_zero(pixel_zero), .dac_power_on(power),
    .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_enable(dac_enable)
  );
  serial_host_model host (
    .core_clk(core_clk), .sda_line(sda_line), .scl_pin(scl), .sda_drv(sda_drv)
  );

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task settle;
    begin
      repeat (6) @(posedge core_clk);
      #1;
    end
  endtask
  task w(input [7:0] sub, input [15:0] d, input two);
    begin
      host.wr(sub, d, two, ok);
      chk(ok, 1'b1);
      settle;
    end
  endtask
  task r(input [7:0] sub, input [7:0] exp);
    begin
      host.rd(sub, q, ok);
      chk(ok, 1'b1);
      chk(q, exp);
    end
  endtask
  // Expected DAC sources from extra chroma, output select, component standard and arrangement
  function [29:0] route(input ex, input os, input yp, input ar);
    reg [9:0] a, b, c;
    begin
      b = base + (!os ? 10'h001 : yp ? 10'h007 : 10'h006);
      c = base + (!os ? 10'h003 : yp ? 10'h008 : 10'h004);
      a = base + (ar ? (os && !yp ? 10'h005 : 10'h002) : ex ? 10'h003 : 10'h001);
      route = {a, b, c};
    end
  endfunction

  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    r(8'h03, REV);
    w(8'h03, 16'h00FF, 1'b0);
    r(8'h03, 8'hFC | REV);
    r(8'h05, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      base = {2'b01, i[3:0], 4'h0};
      w(8'h03, {6'h00, i[1], i[2], 3'b000, i[3], i[0], 3'b000}, 1'b1);
      chk({dac_a, dac_b, dac_c}, route(i[3], i[2], i[1], i[0]));
    end
    base = 10'h100;
    w(8'h03, 16'h0000, 1'b1);
    vbi_line = 1'b1;
    settle;
    chk({dac_a, dac_c}, {10'h0F0, 10'h200});
    w(8'h03, 16'h0004, 1'b0);
    chk(dac_a, 10'h101);
    slave_mode0 = 1'b1;
    settle;
    chk(dac_b, 10'h0F0);
    slave_mode0 = 1'b0;
    blank_ctrl = 1'b1;
    settle;
    chk(dac_a, 10'h0F0);
    blank_ctrl = 1'b0;
    vbi_line = 1'b0;
    pixel_zero = 1'b1;
    settle;
    chk(dac_a, 10'h101);
    w(8'h03, 16'h0080, 1'b0);
    chk({dac_a, dac_c}, {10'h0F0, 10'h200});
    pixel_zero = 1'b0;
    ttx_win = 1'b1;
    ttx_pin = 1'b1;
    w(8'h03, 16'h0000, 1'b0);
    chk({ttx_req, dac_a}, {1'b0, 10'h101});
    w(8'h03, 16'h0020, 1'b0);
    chk({ttx_req, dac_a}, {1'b1, 10'h2E0});
    ttx_pin = 1'b0;
    settle;
    chk(dac_a, 10'h0F0);
    w(8'h03, 16'h0060, 1'b0);
    chk(ttx_req, 1'b0);
    ttx_tick = 1'b1;
    @(posedge core_clk);
    #1;
    ttx_tick = 1'b0;
    chk(ttx_req, 1'b1);
    @(posedge core_clk);
    #1;
    chk(ttx_req, 1'b0);
    r(8'h03, 8'h60 | REV);
    ttx_win = 1'b0;
    power = 3'b101;
    settle;
    chk({dac_enable, dac_a, dac_b}, {3'b101, 10'h101, 10'h000});
    power = 3'b010;
    settle;
    chk({dac_a, dac_b, dac_c}, {10'h000, 10'h101, 10'h000});
    reset_n = 1'b0;
    settle;
    chk({dac_enable, dac_b}, 13'h0000);
    reset_n = 1'b1;
    r(8'h03, REV);
    results;
  end

  initial begin
    #6000000;
    fail_count = fail_count + 1;
    results;
  end
endmodule

bind output_mode_regs output_mode_regs_properties chk_inst (
  .core_clk(core_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .slave_mode0(slave_mode0), .blank_input_ctrl(blank_input_ctrl),
  .teletext_window(teletext_window), .teletext_request_pin(teletext_request_pin),
  .vbi_line(vbi_line), .dac_power_on(dac_power_on), .dac_a(dac_a), .dac_b(dac_b),
  .dac_c(dac_c), .dac_enable(dac_enable)
);
